// ===== src/hbi_device.sv
`include "hbi_params.svh"
module hbi_device (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // host port pins
  hbi_if.device bus,
  // write registers and command strobe
  output logic [`HBI_NREG*`HBI_DW-1:0] o_wr_regs,
  output logic o_cmd_stb,
  output logic [`HBI_DW-1:0] o_cmd_code,
  // read register selection
  output logic [`HBI_IW-1:0] o_rd_sel,
  input wire logic [`HBI_DW-1:0] i_rd_data,
  // status
  input wire logic i_irq_pending,
  output logic o_dev_rst,
  output logic o_bus16
);

  ////////////////////////////////////////////////////////////////
  // input sampling
  logic [`HBI_IN_W-1:0] in_raw;
  logic [`HBI_IN_W-1:0] s1_r, s2_r, s3_r, filt_r;
  logic [`HBI_IN_W-1:0] filt_nxt;

  assign in_raw = {bus.host_data_bus, bus.host_addr, bus.hard_reset_low, bus.bus_width_select,
                   bus.chip_select_low, bus.read_strobe_low, bus.write_strobe_low};

  // a bit moves only once stages two and three agree
  always_comb begin
    filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
  end

  // strobe, select and reset pins start inactive (high) so reset does not look like an access
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s1_r <= `HBI_IN_RST;
      s2_r <= `HBI_IN_RST;
      s3_r <= `HBI_IN_RST;
      filt_r <= `HBI_IN_RST;
    end else begin
      s1_r <= in_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // hard reset pin and system clock divider
  logic [2:0] hrst_cnt_r, hrst_cnt_nxt;
  logic dev_rst_r, dev_rst_nxt;
  logic sclk_r, sclk_nxt;
  logic hrst_low;

  assign hrst_low = !filt_r[`HBI_IN_HRST];

  // short glitches on the reset pin must not wipe the registers
  always_comb begin
    hrst_cnt_nxt = hrst_cnt_r;
    dev_rst_nxt = 1'b0;
    if (hrst_low) begin
      if (hrst_cnt_r != `HBI_HRST_MIN) begin
        hrst_cnt_nxt = hrst_cnt_r + 3'h1;
      end
      dev_rst_nxt = (hrst_cnt_nxt == `HBI_HRST_MIN);
    end else begin
      hrst_cnt_nxt = 3'h0;
    end
    // every count here is in input clock cycles, nominally 16 MHz
    sclk_nxt = hrst_low ? 1'b0 : !sclk_r;
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hrst_cnt_r <= 3'h0;
      dev_rst_r <= 1'b0;
      sclk_r <= 1'b0;
    end else begin
      hrst_cnt_r <= hrst_cnt_nxt;
      dev_rst_r <= dev_rst_nxt;
      sclk_r <= sclk_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // address decode
  logic bus16;
  logic [`HBI_AW-1:0] addr;
  logic [`HBI_IW-1:0] idx;
  logic hi_byte;
  logic [`HBI_DW-1:0] din;

  assign bus16 = filt_r[`HBI_IN_WIDTH];
  assign addr = filt_r[`HBI_IN_ADDR +: `HBI_AW];
  assign din = filt_r[`HBI_IN_DATA +: `HBI_DW];
  // 16-bit mode ignores the top address bit, 8-bit mode picks bytes
  assign idx = bus16 ? addr[2:0] : addr[3:1];
  assign hi_byte = !bus16 && addr[0];

  ////////////////////////////////////////////////////////////////
  // write path, command strobe and busy
  logic [`HBI_DW-1:0] regs_r [`HBI_NREG];
  logic [`HBI_DW-1:0] regs_nxt [`HBI_NREG];
  logic wr_prev_r;
  logic wr_rise;
  logic [2:0] busy_cnt_r, busy_cnt_nxt;
  logic busy_n_r, busy_n_nxt;
  logic cmd_stb_r, cmd_stb_nxt;
  logic is_cmd, cmd_done;

  // data and address are taken from the same sampled bundle as the strobe
  assign wr_rise = filt_r[`HBI_IN_WR] && !wr_prev_r && !filt_r[`HBI_IN_CS];
  assign is_cmd = (idx == `HBI_CMD_IDX);
  // a command fires on its whole word, or on its high byte in 8-bit mode
  assign cmd_done = bus16 || hi_byte;

  always_comb begin
    for (int i = 0; i < `HBI_NREG; i++) begin
      regs_nxt[i] = regs_r[i];
    end
    busy_cnt_nxt = (busy_cnt_r != 3'h0) ? busy_cnt_r - 3'h1 : 3'h0;
    cmd_stb_nxt = 1'b0;
    // writes to the command location while busy are dropped whole
    if (wr_rise && !(is_cmd && busy_cnt_r != 3'h0)) begin
      if (bus16) begin
        regs_nxt[idx] = din;
      end else if (hi_byte) begin
        regs_nxt[idx][15:8] = din[7:0];
      end else begin
        regs_nxt[idx][7:0] = din[7:0];
      end
      if (is_cmd && cmd_done) begin
        cmd_stb_nxt = 1'b1;
        busy_cnt_nxt = `HBI_BUSY_CLKS;
      end
    end
    busy_n_nxt = (busy_cnt_nxt == 3'h0);
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < `HBI_NREG; i++) begin
        regs_r[i] <= `HBI_WREG_RST;
      end
      wr_prev_r <= 1'b1;
      busy_cnt_r <= 3'h0;
      busy_n_r <= 1'b1;
      cmd_stb_r <= 1'b0;
    end else if (dev_rst_r) begin
      // pin reset returns the registers to their initial values
      for (int i = 0; i < `HBI_NREG; i++) begin
        regs_r[i] <= `HBI_WREG_RST;
      end
      wr_prev_r <= 1'b1;
      busy_cnt_r <= 3'h0;
      busy_n_r <= 1'b1;
      cmd_stb_r <= 1'b0;
    end else begin
      for (int i = 0; i < `HBI_NREG; i++) begin
        regs_r[i] <= regs_nxt[i];
      end
      wr_prev_r <= filt_r[`HBI_IN_WR];
      busy_cnt_r <= busy_cnt_nxt;
      busy_n_r <= busy_n_nxt;
      cmd_stb_r <= cmd_stb_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // read path and interrupt
  logic [`HBI_DW-1:0] dout_r, dout_nxt;
  logic [1:0] doe_n_r, doe_n_nxt;
  logic irq_oe_n_r, irq_oe_n_nxt;
  logic rd_sel;

  assign rd_sel = !filt_r[`HBI_IN_CS] && !filt_r[`HBI_IN_RD];

  // upper lanes stay released in 8-bit mode for their pull-ups
  always_comb begin
    doe_n_nxt = 2'b11;
    dout_nxt = 16'h0000;
    if (rd_sel) begin
      doe_n_nxt = bus16 ? 2'b00 : 2'b10;
      dout_nxt = bus16 ? i_rd_data : {8'h00, hi_byte ? i_rd_data[15:8] : i_rd_data[7:0]};
    end
    irq_oe_n_nxt = !i_irq_pending;
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dout_r <= 16'h0000;
      doe_n_r <= 2'b11;
      irq_oe_n_r <= 1'b1;
    end else begin
      dout_r <= dout_nxt;
      doe_n_r <= doe_n_nxt;
      irq_oe_n_r <= irq_oe_n_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs
  for (genvar g = 0; g < `HBI_NREG; g++) begin : g_regs
    assign o_wr_regs[g*`HBI_DW +: `HBI_DW] = regs_r[g];
  end
  assign o_cmd_stb = cmd_stb_r;
  assign o_cmd_code = regs_r[`HBI_CMD_IDX];
  assign o_rd_sel = idx;
  assign o_dev_rst = dev_rst_r;
  assign o_bus16 = bus16;
  assign bus.dev_data_out = dout_r;
  assign bus.dev_data_oe_n = doe_n_r;
  assign bus.cmd_busy_low = busy_n_r;
  assign bus.irq_out = 1'b0; // open drain: only ever pulls low
  assign bus.irq_oe_n = irq_oe_n_r;
  assign bus.sys_clk = sclk_r;

endmodule

// ===== src/hbi_host.sv
`include "hbi_params.svh"
module hbi_host (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // device pins
  hbi_if.host bus,
  // access requests
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [`HBI_AW-1:0] i_req_addr,
  input wire logic [`HBI_DW-1:0] i_req_wdata,
  output logic o_req_ready,
  // read answers
  output logic [`HBI_DW-1:0] o_rd_data,
  output logic o_rd_valid,
  // control and status
  input wire logic i_bus16,
  input wire logic i_hard_reset_req,
  output logic o_irq,
  output logic o_busy
);

  ////////////////////////////////////////////////////////////////
  // device output sampling
  logic [`HBI_HIN_W-1:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;

  always_comb begin
    filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s1_r <= `HBI_HIN_RST;
      s2_r <= `HBI_HIN_RST;
      s3_r <= `HBI_HIN_RST;
      filt_r <= `HBI_HIN_RST;
    end else begin
      s1_r <= {bus.host_data_bus, bus.irq_out_low, bus.cmd_busy_low};
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // access sequencer
  hbi_pkg::hbi_state_type st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [3:0] gap_r, gap_nxt;
  logic cs_n_r, cs_n_nxt, rd_n_r, rd_n_nxt, wr_n_r, wr_n_nxt;
  logic hrst_n_r, hrst_n_nxt, doe_n_r, doe_n_nxt, write_r, write_nxt;
  logic rvalid_r, rvalid_nxt;
  hbi_pkg::hbi_addr_type addr_r, addr_nxt;
  hbi_pkg::hbi_word_type dout_r, dout_nxt, rdata_r, rdata_nxt;
  logic req_cmd, cur_cmd, busy_f, ready;

  // the command lives at word 0; in 8-bit mode its high byte fires it
  assign req_cmd = i_req_write && (i_bus16 ? (i_req_addr[2:0] == 3'h0) : (i_req_addr[3:0] == 4'h1));
  assign cur_cmd = write_r && (i_bus16 ? (addr_r[2:0] == 3'h0) : (addr_r == 4'h1));
  assign busy_f = !filt_r[`HBI_HIN_BUSY];
  // a command waits for the device to finish the previous one
  assign ready = (st_r == hbi_pkg::HBI_ST_IDLE) && !i_hard_reset_req &&
                 !(req_cmd && (busy_f || gap_r != 4'h0));

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = (cnt_r != 4'h0) ? cnt_r - 4'h1 : 4'h0;
    gap_nxt = (gap_r != 4'h0) ? gap_r - 4'h1 : 4'h0;
    cs_n_nxt = cs_n_r;
    rd_n_nxt = rd_n_r;
    wr_n_nxt = wr_n_r;
    hrst_n_nxt = hrst_n_r;
    doe_n_nxt = doe_n_r;
    write_nxt = write_r;
    addr_nxt = addr_r;
    dout_nxt = dout_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    case (st_r)
      hbi_pkg::HBI_ST_RESET: begin
        // reset pin held low for longer than four clocks
        hrst_n_nxt = 1'b0;
        if (cnt_r == 4'h0) begin
          hrst_n_nxt = 1'b1;
          st_nxt = hbi_pkg::HBI_ST_IDLE;
        end
      end
      hbi_pkg::HBI_ST_IDLE: begin
        if (i_hard_reset_req) begin
          st_nxt = hbi_pkg::HBI_ST_RESET;
          cnt_nxt = `HBI_H_RST_CLKS;
          hrst_n_nxt = 1'b0;
        end else if (i_req_valid && ready) begin
          st_nxt = hbi_pkg::HBI_ST_SETUP;
          cnt_nxt = `HBI_H_SETUP;
          cs_n_nxt = 1'b0;
          write_nxt = i_req_write;
          addr_nxt = i_req_addr;
          dout_nxt = i_bus16 ? i_req_wdata : {8'h00, i_req_wdata[7:0]};
          doe_n_nxt = !i_req_write;
        end
      end
      hbi_pkg::HBI_ST_SETUP: begin
        if (cnt_r == 4'h0) begin
          st_nxt = hbi_pkg::HBI_ST_STROBE;
          cnt_nxt = `HBI_H_STROBE;
          wr_n_nxt = !write_r;
          rd_n_nxt = write_r;
        end
      end
      hbi_pkg::HBI_ST_STROBE: begin
        if (cnt_r == 4'h0) begin
          st_nxt = hbi_pkg::HBI_ST_HOLD;
          cnt_nxt = `HBI_H_HOLD;
          wr_n_nxt = 1'b1;
          rd_n_nxt = 1'b1;
          if (!write_r) begin
            rdata_nxt = i_bus16 ? filt_r[`HBI_HIN_DATA +: `HBI_DW] : {8'h00, filt_r[`HBI_HIN_DATA +: 8]};
            rvalid_nxt = 1'b1;
          end
        end
      end
      hbi_pkg::HBI_ST_HOLD: begin
        // address, select and data stay put past the strobe rise
        if (cnt_r == 4'h0) begin
          st_nxt = hbi_pkg::HBI_ST_IDLE;
          cs_n_nxt = 1'b1;
          doe_n_nxt = 1'b1;
          if (cur_cmd) begin
            gap_nxt = `HBI_H_CMD_GAP;
          end
        end
      end
      default: begin
        st_nxt = hbi_pkg::HBI_ST_IDLE;
      end
    endcase
  end

  // reset state issues the power-up reset pulse on the pin
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r <= hbi_pkg::HBI_ST_RESET;
      cnt_r <= `HBI_H_RST_CLKS;
      gap_r <= 4'h0;
      cs_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      hrst_n_r <= 1'b0;
      doe_n_r <= 1'b1;
      write_r <= 1'b0;
      addr_r <= 4'h0;
      dout_r <= 16'h0000;
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      gap_r <= gap_nxt;
      cs_n_r <= cs_n_nxt;
      rd_n_r <= rd_n_nxt;
      wr_n_r <= wr_n_nxt;
      hrst_n_r <= hrst_n_nxt;
      doe_n_r <= doe_n_nxt;
      write_r <= write_nxt;
      addr_r <= addr_nxt;
      dout_r <= dout_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs
  assign bus.chip_select_low = cs_n_r;
  assign bus.read_strobe_low = rd_n_r;
  assign bus.write_strobe_low = wr_n_r;
  assign bus.host_addr = addr_r;
  assign bus.bus_width_select = i_bus16;
  assign bus.hard_reset_low = hrst_n_r;
  assign bus.host_data_out = dout_r;
  assign bus.host_data_oe_n = doe_n_r;
  assign o_req_ready = ready;
  assign o_rd_data = rdata_r;
  assign o_rd_valid = rvalid_r;
  assign o_irq = !filt_r[`HBI_HIN_IRQ];
  assign o_busy = busy_f;

endmodule

// ===== src/hbi_if.sv
`include "hbi_params.svh"
interface hbi_if;
  // host driven pins
  logic chip_select_low;
  logic read_strobe_low;
  logic write_strobe_low;
  logic [`HBI_AW-1:0] host_addr;
  logic bus_width_select;
  logic hard_reset_low;
  // host drive of the data bus
  logic [`HBI_DW-1:0] host_data_out;
  logic host_data_oe_n;
  // device drive of the data bus, one enable per byte lane
  logic [`HBI_DW-1:0] dev_data_out;
  logic [1:0] dev_data_oe_n;
  // device outputs
  logic cmd_busy_low;
  logic irq_out;
  logic irq_oe_n;
  logic sys_clk;
  // resolved wire levels; undriven lanes float up on pull-ups
  logic [`HBI_DW-1:0] host_data_bus;
  logic irq_out_low;
  assign host_data_bus[7:0] = !dev_data_oe_n[0] ? dev_data_out[7:0] :
                              !host_data_oe_n ? host_data_out[7:0] : 8'hFF;
  assign host_data_bus[15:8] = !dev_data_oe_n[1] ? dev_data_out[15:8] :
                               !host_data_oe_n ? host_data_out[15:8] : 8'hFF;
  assign irq_out_low = !irq_oe_n ? irq_out : 1'b1;

  modport device (
    input chip_select_low, read_strobe_low, write_strobe_low, host_addr,
    input bus_width_select, hard_reset_low, host_data_bus,
    output dev_data_out, dev_data_oe_n, cmd_busy_low, irq_out, irq_oe_n, sys_clk
  );
  modport host (
    output chip_select_low, read_strobe_low, write_strobe_low, host_addr,
    output bus_width_select, hard_reset_low, host_data_out, host_data_oe_n,
    input host_data_bus, cmd_busy_low, irq_out_low, sys_clk
  );
endinterface

// ===== src/hbi_params.svh
`ifndef HBI_PARAMS_SVH
`define HBI_PARAMS_SVH

// widths and register file shape
`define HBI_DW 16
`define HBI_AW 4
`define HBI_NREG 8
`define HBI_IW 3
`define HBI_CMD_IDX 3'h0
`define HBI_WREG_RST 16'h0000

// bit positions in the sampled input bundle of the device
`define HBI_IN_WR 0
`define HBI_IN_RD 1
`define HBI_IN_CS 2
`define HBI_IN_WIDTH 3
`define HBI_IN_HRST 4
`define HBI_IN_ADDR 5
`define HBI_IN_DATA 9
`define HBI_IN_W 25
`define HBI_IN_RST 25'h0000017

// bit positions in the sampled input bundle of the host
`define HBI_HIN_BUSY 0
`define HBI_HIN_IRQ 1
`define HBI_HIN_DATA 2
`define HBI_HIN_W 18
`define HBI_HIN_RST 18'h00003

// timing counts in input clock cycles
`define HBI_NOM_CLK_HZ 16000000
`define HBI_BUSY_CLKS 3'h3
`define HBI_HRST_MIN 3'h5
`define HBI_H_RST_CLKS 4'h8
`define HBI_H_SETUP 4'h2
`define HBI_H_STROBE 4'hC
`define HBI_H_HOLD 4'h6
`define HBI_H_CMD_GAP 4'h8

`endif

// ===== src/hbi_pkg.sv
`include "hbi_params.svh"
package hbi_pkg;
  typedef logic [`HBI_DW-1:0] hbi_word_type;
  typedef logic [`HBI_AW-1:0] hbi_addr_type;
  // host access sequencer, one-hot
  typedef enum logic [4:0] {
    HBI_ST_RESET = 5'b00001,
    HBI_ST_IDLE = 5'b00010,
    HBI_ST_SETUP = 5'b00100,
    HBI_ST_STROBE = 5'b01000,
    HBI_ST_HOLD = 5'b10000
  } hbi_state_type;
endpackage

// ===== testbench/hbi_properties.sv
`include "hbi_params.svh"
module hbi_properties (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // host driven pins
  input wire logic chip_select_low,
  input wire logic read_strobe_low,
  input wire logic write_strobe_low,
  input wire logic [`HBI_AW-1:0] host_addr,
  input wire logic bus_width_select,
  input wire logic hard_reset_low,
  input wire logic [`HBI_DW-1:0] host_data_out,
  input wire logic host_data_oe_n,
  // device driven pins
  input wire logic [1:0] dev_data_oe_n,
  input wire logic cmd_busy_low,
  input wire logic irq_out,
  input wire logic irq_oe_n,
  input wire logic sys_clk,
  input wire logic irq_out_low
);
  timeunit 1ns;
  timeprecision 100ps;
  logic cmd_addr;

  ////////////////////////////////////////////////////////////
  // command decode; top address bit only counts in byte mode
  assign cmd_addr = bus_width_select ? (host_addr[2:0] == 3'h0) : (host_addr == 4'h1);

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);

  ////////////////////////////////////////////////////////////
  // data bus ownership during reads
  AST_DRIVE_START:
    assert property (dev_data_oe_n != 2'b11 && $past(dev_data_oe_n) == 2'b11 |-> !chip_select_low && !read_strobe_low)
    else $error("data bus driven outside a read");
  AST_DRIVE_END:
    assert property ($rose(read_strobe_low) |-> ##[1:8] dev_data_oe_n == 2'b11)
    else $error("data bus not released after read");
  AST_READ_LANES:
    assert property ((!chip_select_low && !read_strobe_low) [*8] |-> !dev_data_oe_n[0] && dev_data_oe_n[1] == !bus_width_select)
    else $error("wrong byte lanes driven in read");

  ////////////////////////////////////////////////////////////
  // command busy window, bounded so a stuck busy is caught
  AST_CMD_BUSY:
    assert property ($rose(write_strobe_low) && !chip_select_low && cmd_addr && cmd_busy_low |-> ##[3:8] !cmd_busy_low)
    else $error("command write gave no busy");
  AST_BUSY_LEN:
    assert property ($fell(cmd_busy_low) |-> !cmd_busy_low [*3] ##1 cmd_busy_low)
    else $error("busy length wrong");
  AST_BUSY_CAUSE:
    assert property ($fell(cmd_busy_low) |-> !chip_select_low && write_strobe_low && cmd_addr)
    else $error("busy without a command write");
  AST_HOST_CMD_WAIT:
    assert property ($fell(write_strobe_low) && cmd_addr |-> cmd_busy_low)
    else $error("command written while busy");

  ////////////////////////////////////////////////////////////
  // host write framing
  AST_WR_STABLE:
    assert property (!write_strobe_low && !$past(write_strobe_low) |-> !chip_select_low && $stable(host_addr))
    else $error("select or address moved in write");
  AST_WR_HOLD:
    assert property ($rose(write_strobe_low) |-> (!host_data_oe_n && !chip_select_low && $stable(host_data_out)) [*5])
    else $error("write data not held after strobe");

  ////////////////////////////////////////////////////////////
  // interrupt pin and system clock
  AST_IRQ_DRAIN:
    assert property (!irq_oe_n |-> !irq_out && !irq_out_low)
    else $error("interrupt pin driven high");
  AST_SCLK_HALF:
    assert property (hard_reset_low [*8] |-> sys_clk != $past(sys_clk))
    else $error("system clock not half rate");
  AST_SCLK_STOP:
    assert property ((!hard_reset_low) [*8] |-> !sys_clk)
    else $error("system clock runs in reset");
endmodule

// ===== testbench/tb_top.sv
`include "hbi_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; $display("Error at %0t: got %h exp %h", $time, (g), (e)); end end

  logic ref_clk;
  logic sys_rst;
  logic [`HBI_NREG*`HBI_DW-1:0] wr_regs;
  logic cmd_stb;
  hbi_pkg::hbi_word_type cmd_code;
  logic [`HBI_IW-1:0] rd_sel;
  hbi_pkg::hbi_word_type rd_data;
  logic irq_pend;
  logic dev_rst;
  logic dev_bus16;
  logic req_valid;
  logic req_write;
  hbi_pkg::hbi_addr_type req_addr;
  hbi_pkg::hbi_word_type req_wdata;
  logic req_ready;
  hbi_pkg::hbi_word_type host_rdata;
  logic host_rvalid;
  logic bus16;
  logic hrst_req;
  logic host_irq;
  logic host_busy;
  hbi_pkg::hbi_word_type rd_mem [8];
  hbi_pkg::hbi_word_type exp_regs [8];
  hbi_pkg::hbi_word_type rd_q [$];
  hbi_pkg::hbi_word_type cmd_q [$];
  hbi_pkg::hbi_word_type want;
  logic rst_seen;
  int errors;
  int checked;
  int n;

  ////////////////////////////////////////////////////////////
  // both ends joined; read answers come from a fixed table
  assign rd_data = rd_mem[rd_sel];
  hbi_if hbi_if_inst ();
  hbi_device hbi_device_inst (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .bus(hbi_if_inst), .o_wr_regs(wr_regs),
    .o_cmd_stb(cmd_stb), .o_cmd_code(cmd_code), .o_rd_sel(rd_sel), .i_rd_data(rd_data),
    .i_irq_pending(irq_pend), .o_dev_rst(dev_rst), .o_bus16(dev_bus16));
  hbi_host hbi_host_inst (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .bus(hbi_if_inst), .i_req_valid(req_valid),
    .i_req_write(req_write), .i_req_addr(req_addr), .i_req_wdata(req_wdata), .o_req_ready(req_ready),
    .o_rd_data(host_rdata), .o_rd_valid(host_rvalid), .i_bus16(bus16), .i_hard_reset_req(hrst_req),
    .o_irq(host_irq), .o_busy(host_busy));
  hbi_properties hbi_properties_inst (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst),
    .chip_select_low(hbi_if_inst.chip_select_low), .read_strobe_low(hbi_if_inst.read_strobe_low),
    .write_strobe_low(hbi_if_inst.write_strobe_low), .host_addr(hbi_if_inst.host_addr),
    .bus_width_select(hbi_if_inst.bus_width_select), .hard_reset_low(hbi_if_inst.hard_reset_low),
    .host_data_out(hbi_if_inst.host_data_out), .host_data_oe_n(hbi_if_inst.host_data_oe_n),
    .dev_data_oe_n(hbi_if_inst.dev_data_oe_n), .cmd_busy_low(hbi_if_inst.cmd_busy_low),
    .irq_out(hbi_if_inst.irq_out), .irq_oe_n(hbi_if_inst.irq_oe_n), .sys_clk(hbi_if_inst.sys_clk),
    .irq_out_low(hbi_if_inst.irq_out_low));

  ////////////////////////////////////////////////////////////
  // verdict, reached from the main sequence or the watchdog
  task automatic final_report();
    if (errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ready is combinational, so look at it mid-cycle where it has settled
  task automatic wait_ready();
    int c;
    c = 0;
    @(negedge ref_clk);
    while (req_ready !== 1'b1 && c < 200) begin
      @(negedge ref_clk);
      c++;
    end
    if (c >= 200) begin
      errors++;
      final_report();
    end
  endtask

  // one host access; the expectation is noted before the result shows
  task automatic host_op(input logic wr, input hbi_pkg::hbi_addr_type a, input hbi_pkg::hbi_word_type d);
    int k;
    @(posedge ref_clk);
    #1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    wait_ready();
    @(posedge ref_clk);
    #1;
    req_valid = 1'b0;
    req_write = 1'b0;
    k = bus16 ? a[2:0] : a[3:1];
    if (wr && bus16) begin
      exp_regs[k] = d;
    end else if (wr && a[0]) begin
      exp_regs[k][15:8] = d[7:0];
    end else if (wr) begin
      exp_regs[k][7:0] = d[7:0];
    end else begin
      rd_q.push_back(bus16 ? rd_mem[k] : {8'h00, a[0] ? rd_mem[k][15:8] : rd_mem[k][7:0]});
    end
    if (wr && (bus16 ? a[2:0] == 3'h0 : a == 4'h1)) begin
      cmd_q.push_back(exp_regs[0]);
    end
    wait_ready();
    for (k = 0; k < 8; k++) begin
      `CHK(wr_regs[k*16 +: 16], exp_regs[k])
    end
    // a command shows as a short busy at the host, then clears
    if (wr && (bus16 ? a[2:0] == 3'h0 : a == 4'h1)) begin
      for (n = 0; n < 10 && host_busy !== 1'b1; n++) @(negedge ref_clk);
      `CHK(host_busy, 1'b1)
      for (n = 0; n < 10 && host_busy !== 1'b0; n++) @(negedge ref_clk);
      `CHK(host_busy, 1'b0)
    end
  endtask

  ////////////////////////////////////////////////////////////
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // results matched against the oldest note; old values seen at the edge
  always @(posedge ref_clk) begin
    if (host_rvalid === 1'b1) begin
      want = (rd_q.size() > 0) ? rd_q.pop_front() : 16'hXXXX;
      `CHK(host_rdata, want)
    end
    if (cmd_stb === 1'b1) begin
      want = (cmd_q.size() > 0) ? cmd_q.pop_front() : 16'hXXXX;
      `CHK(cmd_code, want)
    end
    if (dev_rst === 1'b1) begin
      rst_seen <= 1'b1;
    end
  end

  // watchdog: the whole sequence needs a few thousand cycles
  initial begin
    #100000;
    errors++;
    final_report();
  end

  // main sequence
  initial begin
    errors = 0;
    checked = 0;
    rst_seen = 1'b0;
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 4'h0;
    req_wdata = 16'h0000;
    bus16 = 1'b1;
    hrst_req = 1'b0;
    irq_pend = 1'b0;
    void'($urandom(48));
    for (int k = 0; k < 8; k++) begin
      rd_mem[k] = 16'($urandom);
      exp_regs[k] = 16'h0000;
    end
    repeat (4) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    wait_ready();
    `CHK(wr_regs, 128'h0)
    // each width twice; every phase opens with three writes, commands at 4'h8 and 4'h0 in 16-bit mode, at 4'h1 only in 8-bit mode
    for (int p = 0; p < 4; p++) begin
      @(posedge ref_clk);
      #1;
      bus16 = ~p[0];
      for (n = 0; n < 20 && dev_bus16 !== bus16; n++) @(negedge ref_clk);
      `CHK(dev_bus16, bus16)
      host_op(1'b1, 4'h8, 16'($urandom));
      host_op(1'b1, 4'h1, 16'($urandom));
      host_op(1'b1, 4'h0, 16'($urandom));
      repeat (12) host_op(1'($urandom), 4'($urandom), 16'($urandom));
    end
    // interrupt raised and released
    @(posedge ref_clk);
    #1;
    irq_pend = 1'b1;
    for (n = 0; n < 20 && host_irq !== 1'b1; n++) @(negedge ref_clk);
    `CHK(hbi_if_inst.irq_out_low, 1'b0)
    `CHK(host_irq, 1'b1)
    @(posedge ref_clk);
    #1;
    irq_pend = 1'b0;
    for (n = 0; n < 20 && host_irq !== 1'b0; n++) @(negedge ref_clk);
    `CHK(hbi_if_inst.irq_out_low, 1'b1)
    // pin reset in mid-run clears what was written
    wait_ready();
    @(posedge ref_clk);
    #1;
    rst_seen = 1'b0;
    hrst_req = 1'b1;
    @(posedge ref_clk);
    #1;
    hrst_req = 1'b0;
    for (n = 0; n < 60 && !(rst_seen === 1'b1 && dev_rst === 1'b0); n++) @(negedge ref_clk);
    `CHK(rst_seen, 1'b1)
    `CHK(wr_regs, 128'h0)
    for (int k = 0; k < 8; k++) begin
      exp_regs[k] = 16'h0000;
    end
    host_op(1'b1, 4'h1, 16'($urandom));
    host_op(1'b0, 4'h3, 16'h0000);
    `CHK(rd_q.size() + cmd_q.size(), 0)
    final_report();
  end
endmodule
